// >>> host_wake_ctl.sv
// host wake control and status register block
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module host_wake_ctl (
   input  wire logic                    mclk,
   input  wire logic                    srst,
   input  wire logic                    warm_rst,
   input  wire logic                    watchdog_rst,
   input  wire logic                    debugger_rst,
   input  wake_ctl_pkg::reg_req_s       req,
   output logic [wake_ctl_pkg::DATA_W-1:0] rd_data,
   input  wake_ctl_pkg::host_pins_s     pins,
   input  wire logic                    host_sw_event_wr,
   output logic                         host_reset_pin_n,
   output logic                         config_access_en,
   output logic [15:0]                  config_base,
   output logic                         irq
);
   import wake_ctl_pkg::*;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic supply_sync;
   // synced active high so the reset value matches an idle pin
   logic bus_reset_sync;

   sync_two u_sync_supply (
      .mclk      (mclk),
      .srst      (srst),
      .pin_in    (pins.supply_present),
      .level_out (supply_sync)
   );

   sync_two u_sync_busrst (
      .mclk      (mclk),
      .srst      (srst),
      .pin_in    (~pins.bus_reset_n),
      .level_out (bus_reset_sync)
   );

   // ***************************************************
   // state
   // ***************************************************
   logic              force_reg;
   logic              force_next;
   logic              valid_reg;
   logic              valid_next;
   logic              lock_reg;
   logic              lock_next;
   logic              mode_reg;
   logic              mode_next;
   logic [7:0]        base_low_reg;
   logic [7:0]        base_low_next;
   logic [7:0]        base_high_reg;
   logic [7:0]        base_high_next;
   logic              wk_sw_reg;
   logic              wk_sw_next;
   logic              hes_sw_reg;
   logic              hes_sw_next;
   logic [IRQ_W-1:0]  irq_sts_reg;
   logic [IRQ_W-1:0]  irq_sts_next;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic [IRQ_W-1:0]  irq_mask_next;
   logic              busrst_prev_reg;
   logic              supply_prev_reg;
   logic [DATA_W-1:0] rd_data_next;

   // ***************************************************
   // address decode
   // ***************************************************
   wire bus_reset_act = bus_reset_sync;
   wire hit_ctl1      = req.addr == CTL1_ADDR;
   wire hit_low       = req.addr == BASE_LOW_ADDR;
   wire hit_high      = req.addr == BASE_HIGH_ADDR;
   wire hit_hes       = req.addr == HES_ADDR;
   wire hit_wk        = req.addr == WK_STS_ADDR;
   wire hit_ists      = req.addr == IRQ_STS_ADDR;
   wire hit_imask     = req.addr == IRQ_MASK_ADDR;
   wire wr_ctl1       = req.wr & hit_ctl1;
   wire wr_low        = req.wr & hit_low & ~lock_reg;
   wire wr_high       = req.wr & hit_high & ~lock_reg;
   wire wr_hes1       = req.wr & hit_hes & req.wdata[SWEV_BIT];
   wire wr_ists       = req.wr & hit_ists;
   wire wr_imask      = req.wr & hit_imask;

   // ***************************************************
   // control register fields
   // ***************************************************
   wire force_wr   = wr_ctl1 ? req.wdata[FORCE_BIT] : force_reg;
   // warm reset wins over a write in the same cycle
   assign force_next = warm_rst ? 1'b0 : force_wr;

   // set by a high byte write wins over the clear
   wire valid_clr  = wr_ctl1 & req.wdata[VALID_BIT] & ~lock_reg;
   assign valid_next = wr_high ? 1'b1 : (valid_clr ? 1'b0 : valid_reg);

   wire lock_clr   = watchdog_rst | debugger_rst;
   wire lock_set   = wr_ctl1 & req.wdata[LOCK_BIT];
   assign lock_next = lock_clr ? 1'b0 : (lock_set | lock_reg);

   wire mode_wr    = wr_ctl1 ? req.wdata[MODE_BIT] : mode_reg;
   assign mode_next = bus_reset_act ? 1'b0 : mode_wr;

   assign base_low_next  = wr_low ? req.wdata : base_low_reg;
   assign base_high_next = wr_high ? req.wdata : base_high_reg;

   // ***************************************************
   // software event status pair
   // ***************************************************
   // mode 0: host write toggles; mode 1: host write sets, core write clears
   wire wk_toggle  = ~mode_reg & host_sw_event_wr;
   wire wk_set1    = mode_reg & host_sw_event_wr;
   wire wk_clr1    = mode_reg & wr_hes1 & ~wk_set1;
   assign wk_sw_next = wk_toggle ? ~wk_sw_reg
                     : (wk_set1 ? 1'b1 : (wk_clr1 ? 1'b0 : wk_sw_reg));

   wire wk_rise    = ~mode_reg & ~wk_sw_reg & wk_sw_next;
   wire hes_set    = wk_rise | wk_set1;
   assign hes_sw_next = hes_set ? 1'b1 : (wr_hes1 ? 1'b0 : hes_sw_reg);

   // ***************************************************
   // interrupt status and mask
   // ***************************************************
   wire [IRQ_W-1:0] irq_ev;
   assign irq_ev[IRQ_HES_BIT]  = hes_set;
   assign irq_ev[IRQ_BRST_BIT] = bus_reset_act & ~busrst_prev_reg;
   assign irq_ev[IRQ_SUP_BIT]  = supply_sync ^ supply_prev_reg;

   wire [IRQ_W-1:0] irq_clr = wr_ists ? req.wdata[IRQ_W-1:0] : IRQ_ZERO;
   // an event in the clearing cycle is kept
   assign irq_sts_next  = irq_ev | (irq_sts_reg & ~irq_clr);
   assign irq_mask_next = wr_imask ? req.wdata[IRQ_W-1:0] : irq_mask_reg;

   // ***************************************************
   // read data
   // ***************************************************
   wire [DATA_W-1:0] ctl1_view = {2'b00,
                                  mode_reg,
                                  lock_reg,
                                  valid_reg,
                                  bus_reset_act,
                                  supply_sync,
                                  force_reg};
   wire [DATA_W-1:0] hes_view  = {1'b0, hes_sw_reg, 6'h00};
   wire [DATA_W-1:0] wk_view   = {1'b0, wk_sw_reg, 6'h00};
   wire [DATA_W-1:0] isv_view  = {5'h00, irq_sts_reg};
   wire [DATA_W-1:0] imk_view  = {5'h00, irq_mask_reg};

   assign rd_data_next = !req.rd  ? BYTE_ZERO
                       : hit_ctl1 ? ctl1_view
                       : hit_low  ? base_low_reg
                       : hit_high ? base_high_reg
                       : hit_hes  ? hes_view
                       : hit_wk   ? wk_view
                       : hit_ists ? isv_view
                       : hit_imask ? imk_view
                       : BYTE_ZERO;

   // ***************************************************
   // flip-flops
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         force_reg     <= 1'b0;
         valid_reg     <= 1'b0;
         lock_reg      <= 1'b0;
         mode_reg      <= 1'b0;
         base_low_reg  <= BYTE_ZERO;
         base_high_reg <= BYTE_ZERO;
      end else begin
         force_reg     <= force_next;
         valid_reg     <= valid_next;
         lock_reg      <= lock_next;
         mode_reg      <= mode_next;
         base_low_reg  <= base_low_next;
         base_high_reg <= base_high_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wk_sw_reg       <= 1'b0;
         hes_sw_reg      <= 1'b0;
         irq_sts_reg     <= IRQ_ZERO;
         irq_mask_reg    <= IRQ_ZERO;
         busrst_prev_reg <= 1'b0;
         supply_prev_reg <= 1'b0;
      end else begin
         wk_sw_reg       <= wk_sw_next;
         hes_sw_reg      <= hes_sw_next;
         irq_sts_reg     <= irq_sts_next;
         irq_mask_reg    <= irq_mask_next;
         busrst_prev_reg <= bus_reset_act;
         supply_prev_reg <= supply_sync;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data          <= BYTE_ZERO;
         host_reset_pin_n <= 1'b1;
         config_access_en <= 1'b0;
         config_base      <= 16'h0000;
         irq              <= 1'b0;
      end else begin
         rd_data          <= rd_data_next;
         host_reset_pin_n <= ~force_reg;
         config_access_en <= valid_reg;
         config_base      <= {base_high_reg, base_low_reg};
         irq              <= |(irq_sts_reg & ~irq_mask_reg);
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   a_reset_pin_drive: assert property (
      @(posedge mclk) disable iff (srst)
      force_reg |=> !host_reset_pin_n)
      else $error("host reset pin not low while force bit set");

   a_warm_clear: assert property (
      @(posedge mclk) disable iff (srst)
      warm_rst |=> !force_reg ##1 host_reset_pin_n)
      else $error("warm reset did not release host reset");

   a_supply_flag: assert property (
      @(posedge mclk) disable iff (srst)
      (req.rd && hit_ctl1) |=> rd_data[SUPPLY_BIT] == $past(supply_sync))
      else $error("supply flag differs from detector");

   a_busrst_flag: assert property (
      @(posedge mclk) disable iff (srst)
      (req.rd && hit_ctl1) |=> rd_data[BUSRST_BIT] == $past(bus_reset_act))
      else $error("bus reset flag wrong");

   a_valid_set: assert property (
      @(posedge mclk) disable iff (srst)
      (req.wr && hit_high && !lock_reg) |=> valid_reg ##1 config_access_en)
      else $error("high byte write did not validate address");

   a_valid_w1c: assert property (
      @(posedge mclk) disable iff (srst)
      (wr_ctl1 && req.wdata[VALID_BIT] && !lock_reg) |=> !valid_reg)
      else $error("write one did not clear valid flag");

   a_valid_access: assert property (
      @(posedge mclk) disable iff (srst)
      !valid_reg |=> !config_access_en)
      else $error("host config access enabled without valid address");

   a_valid_locked: assert property (
      @(posedge mclk) disable iff (srst)
      lock_reg |=> $stable(valid_reg))
      else $error("valid flag changed while locked");

   a_lock_hold: assert property (
      @(posedge mclk) disable iff (srst)
      (lock_reg && !watchdog_rst && !debugger_rst) |=> lock_reg)
      else $error("lock cleared by firmware");

   a_base_locked: assert property (
      @(posedge mclk) disable iff (srst)
      lock_reg |=> $stable(base_low_reg) && $stable(base_high_reg))
      else $error("base address changed while locked");

   a_lock_clear: assert property (
      @(posedge mclk) disable iff (srst)
      (watchdog_rst || debugger_rst) |=> !lock_reg)
      else $error("lock survived watchdog or debugger reset");

   a_mode_busrst: assert property (
      @(posedge mclk) disable iff (srst)
      bus_reset_act |=> !mode_reg)
      else $error("clear mode kept during host bus reset");

   a_sw_toggle: assert property (
      @(posedge mclk) disable iff (srst)
      (!mode_reg && host_sw_event_wr) |=> wk_sw_reg != $past(wk_sw_reg))
      else $error("host write did not toggle wake-up event bit");

   a_hes_follow: assert property (
      @(posedge mclk) disable iff (srst)
      (!mode_reg && !wk_sw_reg && host_sw_event_wr) |=> hes_sw_reg)
      else $error("event status not set on wake-up bit rise");

   a_mode1_clear: assert property (
      @(posedge mclk) disable iff (srst)
      (mode_reg && wr_hes1 && !host_sw_event_wr) |=> !wk_sw_reg && !hes_sw_reg)
      else $error("mode 1 clear left an event bit set");

   a_reserved_zero: assert property (
      @(posedge mclk) disable iff (srst)
      (req.rd && hit_ctl1) |=> rd_data[7:6] == 2'b00)
      else $error("reserved bits read nonzero");

   a_force_write: assert property (
      @(posedge mclk) disable iff (srst)
      (wr_ctl1 && !warm_rst) |=> force_reg == $past(req.wdata[FORCE_BIT]))
      else $error("force bit did not take written value");

   a_lock_set: assert property (
      @(posedge mclk) disable iff (srst)
      (lock_set && !lock_clr) |=> lock_reg)
      else $error("write one did not set lock");

   a_base_write: assert property (
      @(posedge mclk) disable iff (srst)
      wr_high |=> base_high_reg == $past(req.wdata))
      else $error("unlocked high byte write lost");

   a_base_low_write: assert property (
      @(posedge mclk) disable iff (srst)
      wr_low |=> base_low_reg == $past(req.wdata))
      else $error("unlocked low byte write lost");

   a_mode1_set: assert property (
      @(posedge mclk) disable iff (srst)
      (mode_reg && host_sw_event_wr) |=> wk_sw_reg && hes_sw_reg)
      else $error("mode 1 host write did not set both event bits");

   a_rd_idle: assert property (
      @(posedge mclk) disable iff (srst)
      !req.rd |=> rd_data == BYTE_ZERO)
      else $error("read data not zero outside a read");

   a_irq_sticky: assert property (
      @(posedge mclk) disable iff (srst)
      (irq_ev != IRQ_ZERO) |=> (irq_sts_reg & $past(irq_ev)) == $past(irq_ev))
      else $error("interrupt event not latched");

   a_irq_raise: assert property (
      @(posedge mclk) disable iff (srst)
      (|(irq_sts_reg & ~irq_mask_reg)) |=> irq)
      else $error("interrupt low with unmasked status set");

   a_irq_quiet: assert property (
      @(posedge mclk) disable iff (srst)
      !(|(irq_sts_reg & ~irq_mask_reg)) |=> !irq)
      else $error("interrupt high with no unmasked status");

   a_config_base: assert property (
      @(posedge mclk) disable iff (srst)
      valid_reg |=> config_base == {$past(base_high_reg), $past(base_low_reg)})
      else $error("config base does not follow the base bytes");

endmodule : host_wake_ctl

// >>> wake_ctl_pkg.sv
// constants, types and register map of the host wake control block
// How it works
// - while host reset force bit is 1, host reset pin is driven low
// - warm reset clears host reset force; all other bits survive warm reset
// - supply flag reads 1 when host supply is above its on threshold
// - bus reset flag reads 1 while host bus reset input is low
// - write to config base high byte sets the address valid flag
// - writing 1 to address valid clears it; writing 0 keeps it
// - address valid 0 disables host config access; 1 enables base address
// - while lock bit is set, address valid ignores firmware writes
// - writing 1 sets lock bit; firmware can never clear it
// - while locked, writes to both base bytes and valid are ignored
// - lock clears on power-up, watchdog and debugger reset only
// - event clear mode clears on power-up and while host bus reset is active
// - mode 0: each host write of 1 toggles wake-up status bit 6
// - mode 0: rise of wake-up status bit 6 sets host event status bit 6
// - mode 1: core write 1 to host event status clears both bit 6 copies
package wake_ctl_pkg;

   // ***************************************************
   // register bus
   // ***************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_s;

   typedef struct packed {
      logic supply_present;
      logic bus_reset_n;
   } host_pins_s;

   // ***************************************************
   // register offsets
   // ***************************************************
   localparam logic [ADDR_W-1:0] CTL1_ADDR      = 16'hFCC0;
   localparam logic [ADDR_W-1:0] BASE_LOW_ADDR  = 16'hFCC8;
   localparam logic [ADDR_W-1:0] BASE_HIGH_ADDR = 16'hFCCA;
   localparam logic [ADDR_W-1:0] HES_ADDR       = 16'hFCCC;
   localparam logic [ADDR_W-1:0] WK_STS_ADDR    = 16'hFCCE;
   localparam logic [ADDR_W-1:0] IRQ_STS_ADDR   = 16'hFCD0;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR  = 16'hFCD2;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int FORCE_BIT  = 0;
   localparam int SUPPLY_BIT = 1;
   localparam int BUSRST_BIT = 2;
   localparam int VALID_BIT  = 3;
   localparam int LOCK_BIT   = 4;
   localparam int MODE_BIT   = 5;
   localparam int SWEV_BIT   = 6;

   localparam int IRQ_W        = 3;
   localparam int IRQ_HES_BIT  = 0;
   localparam int IRQ_BRST_BIT = 1;
   localparam int IRQ_SUP_BIT  = 2;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [IRQ_W-1:0]  IRQ_ZERO  = 3'h0;
   localparam logic              SYNC_INIT = 1'b0;

endpackage : wake_ctl_pkg

// >>> sync_two.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module sync_two (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic pin_in,
   output logic      level_out
);
   import wake_ctl_pkg::*;

   logic meta_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_reg  <= SYNC_INIT;
         level_out <= SYNC_INIT;
      end else begin
         meta_reg  <= pin_in;
         level_out <= meta_reg;
      end
   end

endmodule : sync_two

// >>> host_side_model.sv
// host side model: drives host supply, host bus reset and host event writes
`timescale 1ns/1ns
module host_side_model (
   input  wire logic               mclk,
   output wake_ctl_pkg::host_pins_s pins,
   output logic                    sw_event_wr
);
   import wake_ctl_pkg::*;

   initial begin
      pins = '{supply_present: 1'b0, bus_reset_n: 1'b1};
      sw_event_wr = 1'b0;
   end

   // pin change, then room for the synchronisers to settle
   task automatic set_pins(input logic sup, input logic brst_n);
      @(posedge mclk);
      pins <= '{supply_present: sup, bus_reset_n: brst_n};
      repeat (4) @(posedge mclk);
   endtask : set_pins

   // one host write of 1 to the software event bit
   task automatic host_event();
      @(posedge mclk);
      sw_event_wr <= 1'b1;
      @(posedge mclk);
      sw_event_wr <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : host_event
endmodule : host_side_model

// >>> host_wake_control_status_tb.sv
// self-checking testbench of the host wake control register block
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module host_wake_control_status_tb;
   import wake_ctl_pkg::*;

   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        warm_rst = 1'b0;
   logic        wdog_rst = 1'b0;
   logic        dbg_rst = 1'b0;
   reg_req_s    req = '0;
   logic [7:0]  rd_data;
   host_pins_s  pins;
   logic        ev_wr;
   logic        pin_n;
   logic        acc_en;
   logic [15:0] base;
   logic        irq;
   int          n_mismatch = 0;
   int          n_checks = 0;

   always #20 mclk = ~mclk;

   host_side_model host (.mclk(mclk), .pins(pins), .sw_event_wr(ev_wr));

   host_wake_ctl dut (.mclk(mclk), .srst(srst), .warm_rst(warm_rst),
      .watchdog_rst(wdog_rst), .debugger_rst(dbg_rst), .req(req), .rd_data(rd_data),
      .pins(pins), .host_sw_event_wr(ev_wr), .host_reset_pin_n(pin_n),
      .config_access_en(acc_en), .config_base(base), .irq(irq));

   // ***************************************************
   // bus tasks
   // ***************************************************
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rc(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge mclk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      `CHK(rd_data & m, e)
   endtask : rc

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : idle

   task automatic pulse(input int which);
      @(posedge mclk);
      if (which == 0) warm_rst <= 1'b1;
      else if (which == 1) wdog_rst <= 1'b1;
      else dbg_rst <= 1'b1;
      @(posedge mclk);
      warm_rst <= 1'b0;
      wdog_rst <= 1'b0;
      dbg_rst <= 1'b0;
   endtask : pulse

   task automatic give_verdict();
      if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   // ***************************************************
   // tests
   // ***************************************************
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      rc(CTL1_ADDR, 8'h00, 8'hFF);
      rc(16'hFCFE, 8'h00, 8'hFF);
      wr(16'hFCFE, 8'hFF);
      wr(CTL1_ADDR, 8'h21);
      idle(1);
      `CHK(pin_n, 1'b0)
      rc(CTL1_ADDR, 8'h21, 8'hFF);
      pulse(0);
      idle(2);
      `CHK(pin_n, 1'b1)
      rc(CTL1_ADDR, 8'h20, 8'hFF);
      wr(CTL1_ADDR, 8'hC0);
      rc(CTL1_ADDR, 8'h00, 8'hFF);
      host.set_pins(1'b1, 1'b1);
      rc(CTL1_ADDR, 8'h02, 8'hFF);
      wr(CTL1_ADDR, 8'h20);
      host.set_pins(1'b1, 1'b0);
      rc(CTL1_ADDR, 8'h06, 8'hFF);
      host.set_pins(1'b1, 1'b1);
      rc(CTL1_ADDR, 8'h02, 8'hFF);
      // interrupt: raise, mask, clear
      rc(IRQ_STS_ADDR, 8'h06, 8'h07);
      wr(IRQ_MASK_ADDR, 8'h00);
      idle(2);
      `CHK(irq, 1'b1)
      wr(IRQ_MASK_ADDR, 8'h06);
      wr(IRQ_STS_ADDR, 8'h07);
      idle(2);
      `CHK(irq, 1'b0)
      // base address, valid flag, lock; freed by watchdog then debugger
      for (int i = 1; i <= 2; i++) begin
         wr(BASE_LOW_ADDR, 8'h34);
         wr(BASE_HIGH_ADDR, 8'h12);
         idle(2);
         `CHK(acc_en, 1'b1)
         `CHK(base, 16'h1234)
         wr(CTL1_ADDR, 8'h00);
         rc(CTL1_ADDR, 8'h08, 8'h18);
         wr(CTL1_ADDR, 8'h10);
         wr(BASE_LOW_ADDR, 8'h56);
         wr(BASE_HIGH_ADDR, 8'h78);
         wr(CTL1_ADDR, 8'h08);
         wr(CTL1_ADDR, 8'h00);
         rc(CTL1_ADDR, 8'h18, 8'h18);
         idle(1);
         `CHK(base, 16'h1234)
         pulse(0);
         rc(CTL1_ADDR, 8'h18, 8'h18);
         pulse(i);
         rc(CTL1_ADDR, 8'h08, 8'h18);
         wr(CTL1_ADDR, 8'h08);
         rc(CTL1_ADDR, 8'h00, 8'h18);
         idle(2);
         `CHK(acc_en, 1'b0)
      end
      // host software event in both clear modes
      wr(CTL1_ADDR, 8'h00);
      host.host_event();
      rc(WK_STS_ADDR, 8'h40, 8'h40);
      rc(HES_ADDR, 8'h40, 8'h40);
      `CHK(irq, 1'b1)
      wr(IRQ_MASK_ADDR, 8'h07);
      idle(2);
      `CHK(irq, 1'b0)
      wr(HES_ADDR, 8'h40);
      host.host_event();
      rc(WK_STS_ADDR, 8'h00, 8'h40);
      rc(HES_ADDR, 8'h00, 8'h40);
      wr(CTL1_ADDR, 8'h20);
      host.host_event();
      rc(WK_STS_ADDR, 8'h40, 8'h40);
      wr(HES_ADDR, 8'h40);
      rc(WK_STS_ADDR, 8'h00, 8'h40);
      rc(HES_ADDR, 8'h00, 8'h40);
      wr(IRQ_STS_ADDR, 8'h07);
      rc(IRQ_STS_ADDR, 8'h00, 8'h07);
      give_verdict();
   end
endmodule : host_wake_control_status_tb
